// >>> logic/sched_pkg.sv
// Purpose: Shared constants and types for the isochronous split microframe scheduler
// Assumes: Classic Wishbone slave with 32-bit data and byte addresses
// Notes: All register offsets are byte addresses of aligned words
package sched_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int UF_N = 8;
    localparam int STAT_W = 3;
    localparam int CNT_W = 8;
    localparam int ADR_W = 8;
    localparam int FRM_W = 5;
    localparam int IRQ_W = 4;
    typedef logic [2:0] uf_idx_type;
    typedef logic [STAT_W-1:0] uf_stat_type;
    typedef logic [CNT_W-1:0] uf_cnt_type;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [ADR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] OFF_FRAME = 8'h04;
    localparam logic [ADR_W-1:0] OFF_MASK = 8'h08;
    localparam logic [ADR_W-1:0] OFF_STAT = 8'h0c;
    localparam logic [ADR_W-1:0] OFF_CNT_LO = 8'h10;
    localparam logic [ADR_W-1:0] OFF_CNT_HI = 8'h14;
    localparam logic [ADR_W-1:0] OFF_SUM = 8'h18;
    localparam logic [ADR_W-1:0] OFF_IRQ_ST = 8'h1c;
    localparam logic [ADR_W-1:0] OFF_IRQ_MSK = 8'h20;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_ACTIVE = 0;
    localparam int CTRL_TOK_IN = 1;
    localparam int CTRL_SC = 2;
    localparam int FRAME_LO = 3;
    localparam int FRAME_HI = 7;
    localparam int MASK_CS_LO = 8;
    localparam int STAT_BASE = 8;
    localparam int ST_XERR = 0;
    localparam int ST_BABBLE = 1;
    localparam int ST_UNDER = 2;
    localparam int SUM_XERR = 0;
    localparam int SUM_BABBLE = 1;
    localparam int SUM_HALT = 2;
    localparam int IRQ_SS = 0;
    localparam int IRQ_CS = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_DONE = 3;
    localparam uf_idx_type IN_UF_LIMIT = 3'h4;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_RECORD, S_CLEAR} sched_state_type;
endpackage

// >>> logic/rec_if.sv
// Purpose: Carries result writes and stored fields between scheduler and result store
// Assumes: One clock domain
// Notes: Flat vectors pack microframe 0 in the lowest field
`timescale 1ns/100ps
`default_nettype none
interface rec_if;
    import sched_pkg::*;
    logic wr;
    logic clr;
    uf_idx_type idx;
    uf_cnt_type bytes;
    uf_stat_type stat;
    logic [UF_N*STAT_W-1:0] stat_flat;
    logic [UF_N*CNT_W-1:0] cnt_flat;
    modport writer (output wr, clr, idx, bytes, stat, input stat_flat, cnt_flat);
    modport store (input wr, clr, idx, bytes, stat, output stat_flat, cnt_flat);
endinterface
`default_nettype wire

// >>> logic/uframe_result_store.sv
// Purpose: Holds per-microframe status and received byte count fields
// Assumes: Writer presents one slot write per cycle at most
// Notes: Clear wipes every slot when a descriptor is armed
`timescale 1ns/100ps
`default_nettype none
module uframe_result_store
    import sched_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    rec_if.store rec
);
    import sched_pkg::*;
    // ----------------------------------------
    // Per-slot storage
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < UF_N; g++) begin : g_slot
            uf_stat_type stat_r;
            uf_cnt_type cnt_r;
            wire logic hit = rec.wr && (rec.idx == uf_idx_type'(g));
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    stat_r <= '0;
                    cnt_r <= '0;
                end else if (rec.clr) begin
                    stat_r <= '0;
                    cnt_r <= '0;
                end else if (hit) begin
                    stat_r <= rec.stat;
                    cnt_r <= rec.bytes;
                end
            end
            assign rec.stat_flat[g*STAT_W +: STAT_W] = stat_r;
            assign rec.cnt_flat[g*CNT_W +: CNT_W] = cnt_r;
        end
    endgenerate
endmodule
`default_nettype wire

// >>> logic/iso_split_microframe_sched.sv
// Purpose: Schedules isochronous start and complete splits per microframe, records results
// Assumes: Classic Wishbone slave; transaction engine reports one result per request
// Notes: Status and count are stored one cycle before the mask bit is cleared
//
// Summary of operation
// [R1] Received byte count stored per microframe when its mask bit set and frame matches.
// [R2] Complete-split mask set by software, cleared by hardware after use, IN only.
// [R3] Start split issued in masked microframe, complete split in its masked microframe.
// [R4] Three-bit status per microframe, packed from bit 8 upward, microframe 7 highest.
// [R5] Status bit 0 transaction error, bit 1 babble IN only, bit 2 underrun OUT only.
// [R6] Start-split mask set by software, each bit cleared by hardware after processing.
// [R7] OUT start split only sent when frame field matches bus frame and bit set.
// [R8] Software sets IN start-split bits only for microframes 0 to 3.
// [R9] Babble and error summaries are the OR of status bits 1 and 0.
// [R10] Halt summary set when a microframe transfer reports stall or halt.
// [R11] Status and count written before the matching mask bit is cleared.
`timescale 1ns/100ps
`default_nettype none
module iso_split_microframe_sched
    import sched_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sched_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic uframe_start,
    input wire logic [sched_pkg::FRM_W-1:0] bus_frame,
    input wire sched_pkg::uf_idx_type bus_uframe,
    output logic ss_req,
    output logic cs_req,
    output sched_pkg::uf_idx_type req_uframe,
    input wire logic xfer_done,
    input wire sched_pkg::uf_cnt_type xfer_bytes,
    input wire logic xfer_err,
    input wire logic xfer_babble,
    input wire logic xfer_underrun,
    input wire logic xfer_stall,
    output logic irq
);
    import sched_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    sched_state_type state_r;
    logic active_r;
    logic tok_in_r;
    logic sc_r;
    logic halt_r;
    logic [7:0] frame_r;
    logic [UF_N-1:0] ss_mask_r;
    logic [UF_N-1:0] cs_mask_r;
    logic [UF_N-1:0] ss_mask_nxt;
    logic [UF_N-1:0] cs_mask_nxt;
    logic [IRQ_W-1:0] irq_st_r;
    logic [IRQ_W-1:0] irq_msk_r;
    uf_idx_type cur_r;
    logic is_cs_r;
    uf_stat_type res_stat_r;
    uf_cnt_type res_bytes_r;
    logic res_stall_r;
    logic ack_r;
    logic [31:0] rdata_r;

    rec_if rec ();

    uframe_result_store u_store (
        .clk(clk),
        .arst_n(arst_n),
        .rec(rec)
    );

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire logic bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    wire logic bus_wr = bus_req && wb_we_i;
    wire logic wr_ctrl = bus_wr && (wb_adr_i == OFF_CTRL) && wb_sel_i[0];
    wire logic wr_frame = bus_wr && (wb_adr_i == OFF_FRAME) && wb_sel_i[0];
    wire logic wr_mask_ss = bus_wr && (wb_adr_i == OFF_MASK) && wb_sel_i[0];
    wire logic wr_mask_cs = bus_wr && (wb_adr_i == OFF_MASK) && wb_sel_i[1];
    wire logic wr_irq_st = bus_wr && (wb_adr_i == OFF_IRQ_ST) && wb_sel_i[0];
    wire logic wr_irq_msk = bus_wr && (wb_adr_i == OFF_IRQ_MSK) && wb_sel_i[0];
    wire logic arm = wr_ctrl && wb_dat_i[CTRL_ACTIVE];

    // ----------------------------------------
    // Scheduling decisions
    // ----------------------------------------
    wire logic frame_ok = (frame_r[FRAME_HI:FRAME_LO] == bus_frame);
    wire logic ss_hit = ss_mask_r[bus_uframe] && (!tok_in_r || bus_uframe < IN_UF_LIMIT); // [R8]
    wire logic cs_hit = tok_in_r && cs_mask_r[bus_uframe]; // [R2]
    wire logic launch = (state_r == S_IDLE) && uframe_start && active_r && frame_ok
        && (ss_hit || cs_hit); // [R3] [R7]
    wire logic launch_cs = !ss_hit;
    wire uf_stat_type done_stat = {!tok_in_r && xfer_underrun, tok_in_r && xfer_babble,
        xfer_err}; // [R5]
    wire logic in_record = (state_r == S_RECORD);
    wire logic in_clear = (state_r == S_CLEAR);
    wire logic [UF_N-1:0] cur_bit = UF_N'(1) << cur_r;
    wire logic [UF_N-1:0] ss_clr = (in_clear && !is_cs_r) ? cur_bit : '0;
    wire logic [UF_N-1:0] cs_clr = (in_clear && is_cs_r) ? cur_bit : '0;
    wire logic masks_empty = ((ss_mask_nxt | cs_mask_nxt) == '0);
    wire logic retire = in_clear && (masks_empty || halt_r);

    // ----------------------------------------
    // Result store writes
    // ----------------------------------------
    wire logic slot_armed = is_cs_r ? cs_mask_r[cur_r] : ss_mask_r[cur_r];
    assign rec.wr = in_record && slot_armed; // [R1] [R11]
    assign rec.clr = arm;
    assign rec.idx = cur_r;
    assign rec.bytes = res_bytes_r;
    assign rec.stat = res_stat_r;

    wire logic [UF_N-1:0] babble_bits;
    wire logic [UF_N-1:0] xerr_bits;
    genvar g;
    generate
        for (g = 0; g < UF_N; g++) begin : g_sum
            assign babble_bits[g] = rec.stat_flat[g*STAT_W + ST_BABBLE];
            assign xerr_bits[g] = rec.stat_flat[g*STAT_W + ST_XERR];
        end
    endgenerate
    wire logic babble_sum = |babble_bits; // [R9]
    wire logic xerr_sum = |xerr_bits; // [R9]

    // ----------------------------------------
    // Masks: software sets, hardware clears
    // ----------------------------------------
    assign ss_mask_nxt = (ss_mask_r & ~ss_clr) | (wr_mask_ss ? wb_dat_i[UF_N-1:0] : '0);
    assign cs_mask_nxt = (cs_mask_r & ~cs_clr)
        | (wr_mask_cs ? wb_dat_i[MASK_CS_LO +: UF_N] : '0);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ss_mask_r <= '0;
            cs_mask_r <= '0;
        end else begin
            ss_mask_r <= ss_mask_nxt; // [R6]
            cs_mask_r <= cs_mask_nxt; // [R2]
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active_r <= 1'b0;
            tok_in_r <= 1'b0;
            sc_r <= 1'b0;
            frame_r <= '0;
        end else begin
            if (wr_ctrl) begin
                active_r <= wb_dat_i[CTRL_ACTIVE];
                tok_in_r <= wb_dat_i[CTRL_TOK_IN];
                sc_r <= sc_r && wb_dat_i[CTRL_SC];
            end else if (retire) begin
                active_r <= 1'b0;
            end
            if (in_clear && !is_cs_r && tok_in_r) begin
                sc_r <= 1'b1;
            end
            if (wr_frame) begin
                frame_r <= wb_dat_i[7:0];
            end
        end
    end

    // ----------------------------------------
    // Split sequencer
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= S_IDLE;
            cur_r <= '0;
            is_cs_r <= 1'b0;
            ss_req <= 1'b0;
            cs_req <= 1'b0;
            req_uframe <= '0;
        end else begin
            ss_req <= launch && !launch_cs;
            cs_req <= launch && launch_cs;
            unique case (state_r)
                S_IDLE: begin
                    if (launch) begin
                        state_r <= S_WAIT;
                        cur_r <= bus_uframe;
                        is_cs_r <= launch_cs;
                        req_uframe <= bus_uframe;
                    end
                end
                S_WAIT: begin
                    if (xfer_done) begin
                        state_r <= S_RECORD;
                    end
                end
                S_RECORD: state_r <= S_CLEAR; // [R11]
                S_CLEAR: state_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            res_stat_r <= '0;
            res_bytes_r <= '0;
            res_stall_r <= 1'b0;
        end else if (state_r == S_WAIT && xfer_done) begin
            res_stat_r <= done_stat; // [R5]
            res_bytes_r <= xfer_bytes; // [R1]
            res_stall_r <= xfer_stall;
        end
    end

    // ----------------------------------------
    // Halt summary
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            halt_r <= 1'b0;
        end else if (in_record && res_stall_r) begin
            halt_r <= 1'b1; // [R10]
        end else if (arm) begin
            halt_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    wire logic [IRQ_W-1:0] irq_ev;
    assign irq_ev[IRQ_SS] = in_clear && !is_cs_r;
    assign irq_ev[IRQ_CS] = in_clear && is_cs_r;
    assign irq_ev[IRQ_ERR] = in_record && ((res_stat_r != '0) || res_stall_r);
    assign irq_ev[IRQ_DONE] = retire;
    wire logic [IRQ_W-1:0] irq_w1c = wr_irq_st ? wb_dat_i[IRQ_W-1:0] : '0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_st_r <= '0;
            irq_msk_r <= '0;
        end else begin
            irq_st_r <= (irq_st_r & ~irq_w1c) | irq_ev;
            if (wr_irq_msk) begin
                irq_msk_r <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irq_st_r & irq_msk_r);

    // ----------------------------------------
    // Read path and acknowledge
    // ----------------------------------------
    wire logic [31:0] rd_ctrl = {29'h0, sc_r, tok_in_r, active_r};
    wire logic [31:0] rd_mask = {16'h0, cs_mask_r, ss_mask_r};
    wire logic [31:0] rd_stat = {rec.stat_flat, ss_mask_r}; // [R4]
    wire logic [31:0] rd_sum = {29'h0, halt_r, babble_sum, xerr_sum};
    wire logic [31:0] rd_mux =
        (wb_adr_i == OFF_CTRL) ? rd_ctrl :
        (wb_adr_i == OFF_FRAME) ? {24'h0, frame_r} :
        (wb_adr_i == OFF_MASK) ? rd_mask :
        (wb_adr_i == OFF_STAT) ? rd_stat :
        (wb_adr_i == OFF_CNT_LO) ? rec.cnt_flat[31:0] :
        (wb_adr_i == OFF_CNT_HI) ? rec.cnt_flat[63:32] :
        (wb_adr_i == OFF_SUM) ? rd_sum :
        (wb_adr_i == OFF_IRQ_ST) ? {28'h0, irq_st_r} :
        (wb_adr_i == OFF_IRQ_MSK) ? {28'h0, irq_msk_r} :
        RESET_WORD;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
            rdata_r <= RESET_WORD;
        end else begin
            ack_r <= bus_req;
            if (bus_req && !wb_we_i) begin
                rdata_r <= rd_mux;
            end
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_ss_issue;
        @(posedge clk) disable iff (!arst_n)
        (state_r == S_IDLE && uframe_start && active_r && frame_ok && ss_hit)
            |=> (ss_req && !cs_req && req_uframe == $past(bus_uframe));
    endproperty
    a_ss_issue: assert property (p_ss_issue) else $error("start split not issued"); // [R3]

    property p_no_frame_no_req;
        @(posedge clk) disable iff (!arst_n)
        (uframe_start && !frame_ok) |=> !(ss_req || cs_req);
    endproperty
    a_no_frame_no_req: assert property (p_no_frame_no_req) else $error("req on wrong frame"); // [R7]

    property p_cs_in_only;
        @(posedge clk) disable iff (!arst_n)
        cs_req |-> (tok_in_r && cs_mask_r[req_uframe]);
    endproperty
    a_cs_in_only: assert property (p_cs_in_only) else $error("complete split not for IN"); // [R2]

    property p_in_low_uframes;
        @(posedge clk) disable iff (!arst_n)
        (ss_req && tok_in_r) |-> (req_uframe < IN_UF_LIMIT);
    endproperty
    a_in_low_uframes: assert property (p_in_low_uframes) else $error("IN split too late"); // [R8]

    property p_clear_after_record;
        @(posedge clk) disable iff (!arst_n)
        (in_record && !is_cs_r && !wr_mask_ss && ss_mask_r[cur_r])
            |-> ss_mask_r[cur_r] ##1 (1'b1) ##1 !ss_mask_r[$past(cur_r, 2)];
    endproperty
    a_clear_after_record: assert property (p_clear_after_record) else $error("mask order"); // [R6]

    property p_result_stored;
        @(posedge clk) disable iff (!arst_n)
        (rec.wr && !arm) |=> (rec.stat_flat[$past(cur_r)*STAT_W +: STAT_W] == $past(res_stat_r))
            && (rec.cnt_flat[$past(cur_r)*CNT_W +: CNT_W] == $past(res_bytes_r));
    endproperty
    a_result_stored: assert property (p_result_stored) else $error("result not stored"); // [R1]

    property p_dir_status;
        @(posedge clk) disable iff (!arst_n)
        rec.wr |-> (tok_in_r ? !rec.stat[ST_UNDER] : !rec.stat[ST_BABBLE]);
    endproperty
    a_dir_status: assert property (p_dir_status) else $error("status bit wrong direction"); // [R5]

    property p_halt_set;
        @(posedge clk) disable iff (!arst_n)
        (state_r == S_WAIT && xfer_done && xfer_stall) |-> ##2 halt_r;
    endproperty
    a_halt_set: assert property (p_halt_set) else $error("halt not set on stall"); // [R10]

    property p_irq_set_wins;
        @(posedge clk) disable iff (!arst_n)
        (irq_ev[IRQ_SS] && irq_w1c[IRQ_SS]) |=> irq_st_r[IRQ_SS];
    endproperty
    a_irq_set_wins: assert property (p_irq_set_wins) else $error("event lost on clear");
endmodule
`default_nettype wire

// >>> verification/split_engine_model.sv
// Purpose: Behavioural split engine answering each issued split request with one result
// Assumes: Bench presents latency and result fields before the request pulse
// Notes: Result lines other than stall carry changing garbage outside the done pulse; stall holds 0
`timescale 1ns/100ps
`default_nettype none
module split_engine_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ss_req,
    input wire logic cs_req,
    input wire logic [3:0] lat,
    input wire sched_pkg::uf_cnt_type res_bytes,
    input wire logic [3:0] res_flags,
    output logic xfer_done,
    output sched_pkg::uf_cnt_type xfer_bytes,
    output logic xfer_err,
    output logic xfer_babble,
    output logic xfer_underrun,
    output logic xfer_stall
);
    import sched_pkg::*;
    logic [3:0] wait_r;
    // ----------------------------------------
    // One answer per request, lat plus one cycles after the request pulse
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_r <= 4'h0;
            xfer_done <= 1'b0;
        end else begin
            if (ss_req || cs_req) begin
                wait_r <= lat;
            end else if (wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end
            xfer_done <= (wait_r == 4'h1);
        end
    end
    assign xfer_bytes = xfer_done ? res_bytes : ~res_bytes ^ {wait_r, wait_r};
    assign xfer_err = xfer_done ? res_flags[0] : wait_r[0];
    assign xfer_babble = xfer_done ? res_flags[1] : ~wait_r[0];
    assign xfer_underrun = xfer_done ? res_flags[2] : wait_r[1];
    assign xfer_stall = xfer_done ? res_flags[3] : 1'b0;
endmodule
`default_nettype wire

// >>> verification/tb_iso_split_microframe_sched.sv
// Purpose: Self-checking bench for the isochronous split microframe scheduler
// Assumes: Engine model answers every request; one clock domain
// Notes: Expected fields come from an integer model kept beside the run
`timescale 1ns/100ps
`default_nettype none
module tb_iso_split_microframe_sched;
    import sched_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hf;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic uframe_start = 1'b0;
    logic [4:0] bus_frame = 5'h00;
    uf_idx_type bus_uframe = 3'h0;
    logic ss_req, cs_req, xfer_done, xfer_err, xfer_babble, xfer_underrun, xfer_stall, irq;
    uf_idx_type req_uframe;
    uf_cnt_type xfer_bytes;
    logic [3:0] lat = 4'h1;
    uf_cnt_type res_bytes = 8'h00;
    logic [3:0] res_flags = 4'h0;
    int e_stat[8];
    int e_cnt[8];
    logic [7:0] e_ss, e_cs;
    bit halt;
    int n_fail, n_checks, seed;
    logic [31:0] rd;
    always #12.5 clk = ~clk;
    iso_split_microframe_sched i_iso_split_microframe_sched (.clk(clk), .arst_n(arst_n),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .uframe_start(uframe_start), .bus_frame(bus_frame), .bus_uframe(bus_uframe),
        .ss_req(ss_req), .cs_req(cs_req), .req_uframe(req_uframe), .xfer_done(xfer_done),
        .xfer_bytes(xfer_bytes), .xfer_err(xfer_err), .xfer_babble(xfer_babble),
        .xfer_underrun(xfer_underrun), .xfer_stall(xfer_stall), .irq(irq));
    split_engine_model i_split_engine_model (.clk(clk), .arst_n(arst_n), .ss_req(ss_req),
        .cs_req(cs_req), .lat(lat), .res_bytes(res_bytes), .res_flags(res_flags),
        .xfer_done(xfer_done), .xfer_bytes(xfer_bytes), .xfer_err(xfer_err),
        .xfer_babble(xfer_babble), .xfer_underrun(xfer_underrun), .xfer_stall(xfer_stall));
    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic report_and_stop();
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_up();
        n_fail++;
        report_and_stop();
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int i;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= dat;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wb_ack === 1'b1) break;
        end
        if (i == 20) give_up();
        // Data taken and request released at the edge that sees ack
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask
    // ----------------------------------------
    // Reference model of the stored fields
    // ----------------------------------------
    function automatic logic [31:0] stat_word();
        logic [31:0] w;
        w = {24'h0, e_ss};
        for (int u = 0; u < UF_N; u++) w[STAT_BASE+STAT_W*u+:3] = e_stat[u][2:0];
        return w;
    endfunction
    function automatic logic [31:0] cnt_word(input int base);
        logic [31:0] w;
        for (int u = 0; u < 4; u++) w[8*u+:8] = e_cnt[base+u][7:0];
        return w;
    endfunction
    function automatic logic [31:0] sum_word();
        logic [31:0] w;
        w = {29'h0, halt, 2'b00};
        for (int u = 0; u < UF_N; u++) w[1:0] = w[1:0] | e_stat[u][1:0];
        return w;
    endfunction
    task automatic run_uf(input logic [4:0] frm, input int u, input bit tin, input bit stall);
        logic [1:0] ek;
        logic [1:0] gk;
        logic [2:0] gu;
        logic [3:0] fl;
        logic [7:0] by;
        int i;
        ek = 2'd0;
        if (frm == 5'h05 && e_ss[u] && (!tin || u < 4)) ek = 2'd1;
        else if (frm == 5'h05 && tin && e_cs[u]) ek = 2'd2;
        fl = {stall, 3'($urandom)};
        by = 8'($urandom);
        @(posedge clk);
        uframe_start <= 1'b1;
        bus_frame <= frm;
        bus_uframe <= 3'(u);
        lat <= 4'($urandom_range(1, 9));
        res_bytes <= by;
        res_flags <= fl;
        @(posedge clk);
        uframe_start <= 1'b0;
        gk = 2'd0;
        gu = 3'd0;
        for (i = 0; i < 6 && gk == 2'd0; i++) begin
            #1;
            if (ss_req === 1'b1 || cs_req === 1'b1) begin
                gk = {cs_req, ss_req};
                gu = req_uframe;
            end else begin
                @(posedge clk);
            end
        end
        chk({27'h0, gk, gu}, {27'h0, ek, (ek != 2'd0) ? 3'(u) : 3'h0});
        if (ek != 2'd0) begin
            for (i = 0; i < 30; i++) begin
                @(posedge clk);
                #1;
                if (xfer_done === 1'b1) break;
            end
            if (i == 30) give_up();
            repeat (5) @(posedge clk);
            e_stat[u] = {fl[2] & !tin, fl[1] & tin, fl[0]};
            halt = halt | fl[3];
            if (ek == 2'd1) begin
                e_cnt[u] = by;
                e_ss[u] = 1'b0;
            end else begin
                e_cs[u] = 1'b0;
            end
        end
    endtask
    task automatic arm();
        for (int u = 0; u < UF_N; u++) begin
            e_stat[u] = 0;
            e_cnt[u] = 0;
        end
        halt = 0;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        n_fail = 0;
        n_checks = 0;
        seed = $urandom(32'hbdac);
        arm();
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rdc(OFF_STAT, 32'h0);
        rdc(OFF_SUM, 32'h0);
        rdc(OFF_MASK, 32'h0);
        wb(1'b1, 8'h40, 32'hffff_ffff);
        rdc(8'h40, 32'h0);
        // OUT descriptor, random start mask
        e_ss = 8'($urandom) | 8'h01;
        e_cs = 8'h00;
        wb(1'b1, OFF_IRQ_MSK, 32'h1 << IRQ_SS);
        wb(1'b1, OFF_FRAME, 32'h28);
        wb(1'b1, OFF_MASK, {24'h0, e_ss});
        wb(1'b1, OFF_CTRL, 32'h1);
        rdc(OFF_MASK, {16'h0, e_cs, e_ss});
        run_uf(5'h06, 0, 1'b0, 1'b0);
        for (int u = 0; u < UF_N; u++) run_uf(5'h05, u, 1'b0, 1'b0);
        rdc(OFF_STAT, stat_word());
        rdc(OFF_CNT_LO, cnt_word(0));
        rdc(OFF_CNT_HI, cnt_word(4));
        rdc(OFF_SUM, sum_word());
        #1;
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, OFF_IRQ_ST, 32'hf);
        #1;
        chk({31'h0, irq}, 32'h0);
        // IN descriptor: start in uframe 0, complete in uframe 2, stall at the end
        arm();
        e_ss = 8'h01;
        e_cs = 8'h04;
        wb(1'b1, OFF_MASK, 32'h0000_0401);
        wb(1'b1, OFF_CTRL, 32'h3);
        run_uf(5'h05, 1, 1'b1, 1'b0);
        run_uf(5'h05, 0, 1'b1, 1'b0);
        rdc(OFF_MASK, 32'h0000_0400);
        run_uf(5'h05, 2, 1'b1, 1'b1);
        rdc(OFF_MASK, 32'h0);
        rdc(OFF_STAT, stat_word());
        rdc(OFF_SUM, sum_word());
        wb(1'b0, OFF_CNT_LO, 32'h0);
        chk(rd & 32'hff, cnt_word(0) & 32'hff);
        report_and_stop();
    end
endmodule
`default_nettype wire
